// *** cpce_pkg.sv ***
// package for the current/power calculation engine
// assumes one 200 MHz clock and synchronous active-high reset
package cpce_pkg;

  // register pointer values
  localparam logic [7:0] CPCE_OFS_CONFIG = 8'h00;
  localparam logic [7:0] CPCE_OFS_SHUNT  = 8'h01;
  localparam logic [7:0] CPCE_OFS_BUS    = 8'h02;
  localparam logic [7:0] CPCE_OFS_POWER  = 8'h03;
  localparam logic [7:0] CPCE_OFS_CURR   = 8'h04;
  localparam logic [7:0] CPCE_OFS_CAL    = 8'h05;
  localparam int         CPCE_NUM_REGS   = 6;

  // reset values
  localparam logic [15:0] CPCE_CONFIG_RST = 16'h4127;
  localparam logic [15:0] CPCE_ZERO_RST   = 16'h0000;

  // scaling constants
  localparam int          CPCE_CUR_SHIFT  = 11;
  localparam logic [15:0] CPCE_PWR_DIV    = 16'h4E20;
  localparam int          CPCE_PWR_RATIO  = 25;
  localparam int          CPCE_BUS_MSB    = 15;

  // divider length: one quotient bit per cycle
  localparam int          CPCE_DIV_STEPS  = 32;

  // register access request from the serial-bus front end
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  ptr;
    logic [15:0] wdata;
  } cpce_req_t;

  // measurement delivery from the converter
  typedef struct packed {
    logic        shunt_vld;
    logic [15:0] shunt;
    logic        bus_vld;
    logic [15:0] bus;
  } cpce_meas_t;

  typedef enum logic [1:0] {
    CPCE_IDLE = 2'b00,
    CPCE_CUR  = 2'b01,
    CPCE_DIV  = 2'b10,
    CPCE_PWR  = 2'b11
  } cpce_state_t;

endpackage

// *** cpce_divider.sv ***
// unsigned restoring divider, 32-bit dividend by 16-bit divisor
// assumes start is a one-cycle pulse while not busy
`timescale 1ns/1ps
module cpce_divider (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // operands
  input  wire logic        start,
  input  wire logic [31:0] dividend,
  input  wire logic [15:0] divisor,
  // result
  output logic             done,
  output logic [31:0]      quotient
);

  logic [31:0] quo_r;
  logic [16:0] rem_r;
  logic [5:0]  cnt_r;
  logic        busy_r;
  logic        done_r;
  logic [16:0] trial;

  // shifted remainder with next dividend bit
  assign trial = {rem_r[15:0], quo_r[31]};

  // one quotient bit per cycle; slow but tiny, fine for ms-rate data
  always_ff @(posedge clock) begin
    if (reset) begin
      quo_r  <= 32'h0000_0000;
      rem_r  <= 17'h0_0000;
      cnt_r  <= 6'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start && !busy_r) begin
        quo_r  <= dividend;
        rem_r  <= 17'h0_0000;
        cnt_r  <= 6'(cpce_pkg::CPCE_DIV_STEPS);
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (trial >= {1'b0, divisor}) begin
          rem_r <= trial - {1'b0, divisor};
          quo_r <= {quo_r[30:0], 1'b1};
        end else begin
          rem_r <= trial;
          quo_r <= {quo_r[30:0], 1'b0};
        end
        cnt_r <= cnt_r - 6'h01;
        if (cnt_r == 6'h01) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  assign done     = done_r;
  assign quotient = quo_r;

endmodule

// *** cpce_engine.sv ***
// register file and current/power arithmetic of the shunt monitor
// assumes a serial front end that presents decoded register accesses
// and a converter that delivers shunt and bus codes with valid pulses
`timescale 1ns/1ps
module cpce_engine (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 reset,
  // register access
  input  wire cpce_pkg::cpce_req_t  req,
  output logic                      rd_valid,
  output logic [15:0]               rd_data,
  // measurements
  input  wire cpce_pkg::cpce_meas_t meas,
  // configuration to the converter
  output logic [15:0]               config_out
);

  logic [15:0] config_r;
  logic [15:0] shunt_r;
  logic [15:0] bus_r;
  logic [15:0] cal_r;
  logic        cal_set_r;
  logic [15:0] curr_r;
  logic [15:0] power_r;
  logic        rd_valid_r;
  logic [15:0] rd_data_r;
  logic        pend_r;
  cpce_pkg::cpce_state_t state_r;
  cpce_pkg::cpce_state_t state_nxt;
  logic [31:0] curr_prod;
  logic [31:0] curr_shift;
  logic [31:0] curr_mag;
  logic [31:0] curr_abs_q;
  logic        curr_neg;
  logic        div_start_r;
  logic        div_done;
  logic [31:0] div_quo;
  logic [31:0] pwr_dividend_r;
  logic        new_meas;

  // register read decode; unmapped pointers read as zero
  function automatic logic [15:0] reg_read(input logic [7:0] ptr, input logic [15:0] cfg,
    input logic [15:0] sh, input logic [15:0] bu, input logic [15:0] pw,
    input logic [15:0] cu, input logic [15:0] ca);
    unique case (ptr)
      cpce_pkg::CPCE_OFS_CONFIG: reg_read = cfg;
      cpce_pkg::CPCE_OFS_SHUNT:  reg_read = sh;
      cpce_pkg::CPCE_OFS_BUS:    reg_read = bu;
      cpce_pkg::CPCE_OFS_POWER:  reg_read = pw;
      cpce_pkg::CPCE_OFS_CURR:   reg_read = cu;
      cpce_pkg::CPCE_OFS_CAL:    reg_read = ca;
      default:                   reg_read = cpce_pkg::CPCE_ZERO_RST;
    endcase
  endfunction

  // writable registers; defaults reload on every reset
  always_ff @(posedge clock) begin
    if (reset) begin
      config_r  <= cpce_pkg::CPCE_CONFIG_RST;
      cal_r     <= cpce_pkg::CPCE_ZERO_RST;
      cal_set_r <= 1'b0;
    end else if (req.wr) begin
      if (req.ptr == cpce_pkg::CPCE_OFS_CONFIG) begin
        config_r <= req.wdata;
      end
      if (req.ptr == cpce_pkg::CPCE_OFS_CAL) begin
        cal_r     <= req.wdata;
        cal_set_r <= 1'b1;
      end
    end
  end

  // measured codes are stored whatever the calibration holds
  always_ff @(posedge clock) begin
    if (reset) begin
      shunt_r <= cpce_pkg::CPCE_ZERO_RST;
      bus_r   <= cpce_pkg::CPCE_ZERO_RST;
    end else begin
      if (meas.shunt_vld) begin
        shunt_r <= meas.shunt;
      end
      if (meas.bus_vld) begin
        bus_r <= {1'b0, meas.bus[cpce_pkg::CPCE_BUS_MSB-1:0]};
      end
    end
  end

  // current: signed product shifted by 11, truncated toward zero
  // operands widened first so the product is never formed at 17 bits
  assign curr_prod  = $signed({{16{shunt_r[15]}}, shunt_r})
                    * $signed({16'h0000, cal_r});
  assign curr_neg   = curr_prod[31];
  assign curr_mag   = curr_neg ? (32'h0000_0000 - curr_prod) : curr_prod;
  assign curr_abs_q = curr_mag >> cpce_pkg::CPCE_CUR_SHIFT;
  assign curr_shift = curr_neg ? (32'h0000_0000 - curr_abs_q) : curr_abs_q;
  assign new_meas   = meas.shunt_vld | meas.bus_vld;

  // sequencer: capture current, then divide for power
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      cpce_pkg::CPCE_IDLE: if (pend_r && cal_set_r) state_nxt = cpce_pkg::CPCE_CUR;
      cpce_pkg::CPCE_CUR:  state_nxt = cpce_pkg::CPCE_DIV;
      cpce_pkg::CPCE_DIV:  if (div_done) state_nxt = cpce_pkg::CPCE_PWR;
      cpce_pkg::CPCE_PWR:  state_nxt = cpce_pkg::CPCE_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= cpce_pkg::CPCE_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // pending flag: a new sample wins over the clear at sequence start
  always_ff @(posedge clock) begin
    if (reset) begin
      pend_r <= 1'b0;
    end else if (new_meas) begin
      pend_r <= 1'b1;
    end else if (state_r == cpce_pkg::CPCE_IDLE && cal_set_r) begin
      pend_r <= 1'b0;
    end
  end

  // results; held at zero until calibration arrives
  always_ff @(posedge clock) begin
    if (reset || !cal_set_r) begin
      curr_r  <= cpce_pkg::CPCE_ZERO_RST;
      power_r <= cpce_pkg::CPCE_ZERO_RST;
    end else begin
      if (state_r == cpce_pkg::CPCE_CUR) begin
        curr_r <= curr_shift[15:0];
      end
      if (state_r == cpce_pkg::CPCE_PWR) begin
        power_r <= div_quo[15:0];
      end
    end
  end

  // power dividend: magnitude of current times bus; power is unsigned
  always_ff @(posedge clock) begin
    if (reset) begin
      div_start_r    <= 1'b0;
      pwr_dividend_r <= 32'h0000_0000;
    end else begin
      div_start_r <= (state_r == cpce_pkg::CPCE_CUR);
      if (state_r == cpce_pkg::CPCE_CUR) begin
        pwr_dividend_r <= {16'h0000, curr_abs_q[15:0]} * {16'h0000, bus_r};
      end
    end
  end

  // ratio 25 is folded into the fixed divisor, not programmable
  cpce_divider u_div (
    .clock    (clock),
    .reset    (reset),
    .start    (div_start_r),
    .dividend (pwr_dividend_r),
    .divisor  (cpce_pkg::CPCE_PWR_DIV),
    .done     (div_done),
    .quotient (div_quo)
  );

  // registered readback, one cycle after the request
  always_ff @(posedge clock) begin
    if (reset) begin
      rd_valid_r <= 1'b0;
      rd_data_r  <= cpce_pkg::CPCE_ZERO_RST;
    end else begin
      rd_valid_r <= req.rd;
      if (req.rd) begin
        rd_data_r <= reg_read(req.ptr, config_r, shunt_r, bus_r, power_r, curr_r, cal_r);
      end
    end
  end

  assign rd_valid   = rd_valid_r;
  assign rd_data    = rd_data_r;
  assign config_out = config_r;

  // results stay zero while uncalibrated
  property p_uncal_zero;
    @(posedge clock) disable iff (reset)
      !cal_set_r |=> (curr_r == 16'h0000 && power_r == 16'h0000);
  endproperty
  a_uncal_zero: assert property (p_uncal_zero) else $error("results nonzero uncalibrated");

  // bus top bit never read back as set
  property p_bus_msb;
    @(posedge clock) disable iff (reset)
      (req.rd && req.ptr == cpce_pkg::CPCE_OFS_BUS) |=> rd_data_r[15] == 1'b0;
  endproperty
  a_bus_msb: assert property (p_bus_msb) else $error("bus msb set");

  // bus code stored unscaled
  property p_bus_store;
    @(posedge clock) disable iff (reset)
      meas.bus_vld |=> bus_r[14:0] == $past(meas.bus[14:0]);
  endproperty
  a_bus_store: assert property (p_bus_store) else $error("bus code altered");

  // current update equals shunt times cal over 2048, toward zero
  property p_curr_val;
    @(posedge clock) disable iff (reset)
      (state_r == cpce_pkg::CPCE_CUR && cal_set_r) |=> curr_r == $past(16'(
        ($signed({{16{shunt_r[15]}}, shunt_r}) * $signed({16'h0000, cal_r}))
        / (32'sh0000_0001 <<< cpce_pkg::CPCE_CUR_SHIFT)));
  endproperty
  a_curr_val: assert property (p_curr_val) else $error("current value wrong");

  // a calibrated sample reaches the power stage within bound
  property p_recompute;
    @(posedge clock) disable iff (reset)
      (state_r == cpce_pkg::CPCE_CUR) |-> ##[2:40] (state_r == cpce_pkg::CPCE_PWR);
  endproperty
  a_recompute: assert property (p_recompute) else $error("power not recomputed");

  // power result is dividend over 20000
  property p_power_val;
    @(posedge clock) disable iff (reset)
      (state_r == cpce_pkg::CPCE_PWR && cal_set_r)
        |=> power_r == 16'(pwr_dividend_r / {16'h0000, cpce_pkg::CPCE_PWR_DIV});
  endproperty
  a_power_val: assert property (p_power_val) else $error("power value wrong");

  // pending sample with calibration starts a sequence next cycle
  property p_start;
    @(posedge clock) disable iff (reset)
      (state_r == cpce_pkg::CPCE_IDLE && pend_r && cal_set_r) |=> state_r == cpce_pkg::CPCE_CUR;
  endproperty
  a_start: assert property (p_start) else $error("sequence not started");

  // shunt code stored as delivered
  property p_shunt_store;
    @(posedge clock) disable iff (reset)
      meas.shunt_vld |=> shunt_r == $past(meas.shunt);
  endproperty
  a_shunt_store: assert property (p_shunt_store) else $error("shunt not stored");

  // config returns to default after reset
  property p_cfg_default;
    @(posedge clock) reset |=> config_r == cpce_pkg::CPCE_CONFIG_RST && !cal_set_r;
  endproperty
  a_cfg_default: assert property (p_cfg_default) else $error("defaults not reloaded");

endmodule

// *** cpce_host.sv ***
// host model: register reads and writes on the decoded access port
// assumes calls from the bench; requests change at the falling edge
`timescale 1ns/1ps
module cpce_host (
  // clock
  input  wire logic            clock,
  // register access
  output cpce_pkg::cpce_req_t  req,
  input  wire logic            rd_valid,
  input  wire logic [15:0]     rd_data
);
  initial req = '0;

  // one-cycle write strobe, pointer and data held over the taking edge
  task automatic wr_reg(input logic [7:0] p, input logic [15:0] d);
    @(negedge clock);
    req <= '{wr: 1'b1, rd: 1'b0, ptr: p, wdata: d};
    @(negedge clock);
    req.wr <= 1'b0;
  endtask

  // read strobe, then a bounded wait for the answer pulse
  task automatic rd_reg(input logic [7:0] p, output logic [15:0] d);
    int n;
    @(negedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, ptr: p, wdata: 16'h0000};
    @(negedge clock);
    req.rd <= 1'b0;
    n = 0;
    while (rd_valid !== 1'b1 && n < 4) begin
      @(negedge clock);
      n++;
    end
    d = (rd_valid === 1'b1) ? rd_data : 16'hXXXX;
  endtask

  // step size from the largest current, rounded up to a round unit
  function automatic real step_of(input real imax, input real unit);
    return $ceil(imax / 32768.0 / unit) * unit;
  endfunction

  // calibration from step and shunt; +0.5 guards real round-off
  function automatic logic [15:0] cal_of(input real step, input real rsh);
    return 16'($rtoi(0.00512 / (step * rsh) + 0.5));
  endfunction

  // trim by true over reported current, truncated
  function automatic logic [15:0] cal_trim(input logic [15:0] c, input int m, input int r);
    return 16'((int'(c) * m) / r);
  endfunction
endmodule

// *** cpce_engine_tb.sv ***
// bench for the current/power engine with the host model
// assumes results settle within 100 cycles of a measurement pulse
`timescale 1ns/1ps
module cpce_engine_tb;
  logic                 clock = 1'b0;
  logic                 reset = 1'b1;
  cpce_pkg::cpce_req_t  req;
  cpce_pkg::cpce_meas_t meas = '0;
  logic                 rd_valid;
  logic [15:0]          rd_data;
  logic [15:0]          config_out;
  logic [15:0]          v;
  int                   err_count = 0;
  int                   cmp_count = 0;

  // 200 MHz clock
  always #2.5 clock = ~clock;

  cpce_engine dut (
    .clock(clock), .reset(reset), .req(req), .rd_valid(rd_valid),
    .rd_data(rd_data), .meas(meas), .config_out(config_out)
  );
  cpce_host host (.clock(clock), .req(req), .rd_valid(rd_valid), .rd_data(rd_data));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd_chk(input logic [7:0] p, input logic [15:0] exp);
    host.rd_reg(p, v);
    check($sformatf("reg %h", p), exp, v);
  endtask

  // converter pulse; codes turn to junk after it so stale values show
  task automatic send(input logic [15:0] sh, input logic [15:0] bu);
    @(negedge clock);
    meas <= '{shunt_vld: 1'b1, shunt: sh, bus_vld: 1'b1, bus: bu};
    @(negedge clock);
    meas <= '{shunt_vld: 1'b0, shunt: ~sh, bus_vld: 1'b0, bus: ~bu};
    repeat (100) @(negedge clock);
  endtask

  task automatic t_defaults();
    rd_chk(cpce_pkg::CPCE_OFS_CONFIG, 16'h4127);
    check("config_out", cpce_pkg::CPCE_CONFIG_RST, config_out);
    rd_chk(cpce_pkg::CPCE_OFS_CAL, 16'h0000);
    rd_chk(cpce_pkg::CPCE_OFS_CURR, 16'h0000);
    rd_chk(cpce_pkg::CPCE_OFS_POWER, 16'h0000);
  endtask

  task automatic t_uncal();
    send(16'h1F40, 16'h2570);
    rd_chk(cpce_pkg::CPCE_OFS_SHUNT, 16'h1F40);
    rd_chk(cpce_pkg::CPCE_OFS_BUS, 16'h2570);
    rd_chk(cpce_pkg::CPCE_OFS_CURR, 16'h0000);
    rd_chk(cpce_pkg::CPCE_OFS_POWER, 16'h0000);
  endtask

  // top bit dropped; read-only bus refuses a write, unmapped place reads zero
  task automatic t_bus_top();
    send(16'h1F40, 16'hFFFF);
    host.wr_reg(cpce_pkg::CPCE_OFS_BUS, 16'h1234);
    rd_chk(cpce_pkg::CPCE_OFS_BUS, 16'h7FFF);
    rd_chk(8'h06, 16'h0000);
  endtask

  task automatic t_calc();
    host.wr_reg(cpce_pkg::CPCE_OFS_CAL, host.cal_of(host.step_of(15.0, 1.0e-3), 2.0e-3));
    rd_chk(cpce_pkg::CPCE_OFS_CAL, 16'h0A00);
    send(16'h1F40, 16'h2570);
    rd_chk(cpce_pkg::CPCE_OFS_CURR, 16'h2710);
    rd_chk(cpce_pkg::CPCE_OFS_POWER, 16'h12B8);
    send(16'hE0C0, 16'h1388);
    rd_chk(cpce_pkg::CPCE_OFS_CURR, 16'hD8F0);
    rd_chk(cpce_pkg::CPCE_OFS_POWER, 16'h09C4);
    send(16'hFFFD, 16'h2570);
    rd_chk(cpce_pkg::CPCE_OFS_CURR, 16'hFFFD);
    rd_chk(cpce_pkg::CPCE_OFS_POWER, 16'h0001);
  endtask

  task automatic t_trim();
    host.wr_reg(cpce_pkg::CPCE_OFS_CAL, host.cal_trim(16'h0A00, 10100, 10000));
    send(16'h1F40, 16'h2570);
    rd_chk(cpce_pkg::CPCE_OFS_CAL, 16'h0A19);
    rd_chk(cpce_pkg::CPCE_OFS_CURR, 16'h2771);
    rd_chk(cpce_pkg::CPCE_OFS_POWER, 16'h12E6);
  endtask

  // second reset drops the calibration; host must program it again
  task automatic t_rereset();
    host.wr_reg(cpce_pkg::CPCE_OFS_CONFIG, 16'h0127);
    rd_chk(cpce_pkg::CPCE_OFS_CONFIG, 16'h0127);
    check("config_out", 16'h0127, config_out);
    @(negedge clock);
    reset <= 1'b1;
    repeat (2) @(negedge clock);
    reset <= 1'b0;
    rd_chk(cpce_pkg::CPCE_OFS_CONFIG, 16'h4127);
    send(16'h1F40, 16'h2570);
    rd_chk(cpce_pkg::CPCE_OFS_CURR, 16'h0000);
    host.wr_reg(cpce_pkg::CPCE_OFS_CAL, 16'h0A00);
    send(16'h1F40, 16'h2570);
    rd_chk(cpce_pkg::CPCE_OFS_CURR, 16'h2710);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (12) @(negedge clock);
    reset <= 1'b0;
    t_defaults();
    t_uncal();
    t_bus_top();
    t_calc();
    t_trim();
    t_rereset();
    print_verdict();
  end

  // watchdog, well past the roughly 900 cycles the tests need
  initial begin
    #50000;
    err_count++;
    print_verdict();
  end
endmodule
